// [include/cops_pkg.sv]
package cops_pkg;
  // register index on the plain register port
  localparam logic [7:0] COPS_CLKSEL_IDX = 8'h0a;
  localparam logic [7:0] COPS_ROUTE_IDX = 8'h0b;
  // writable bit masks, everything else reserved
  localparam logic [15:0] COPS_CLKSEL_MASK = 16'h03ff;
  localparam logic [15:0] COPS_ROUTE_MASK = 16'hcfff;
  localparam logic [15:0] COPS_CLKSEL_RST = 16'h0020;
  localparam logic [15:0] COPS_ROUTE_RST = 16'h0000;
  // clock_output_select fields
  localparam int COPS_CHOICE_LSB = 6;
  localparam int COPS_DIS_BIT = 5;
  localparam int COPS_SRC_LSB = 0;
  // peripheral_route_select fields
  localparam int COPS_TRATE_BIT = 15;
  localparam int COPS_PRATE_BIT = 14;
  localparam int COPS_PB_LSB = 4;
  localparam int COPS_A5_LSB = 2;
  localparam int COPS_A4_LSB = 0;
  // test clock source codes
  localparam logic [4:0] COPS_SRC_SYS = 5'h00;
  localparam logic [4:0] COPS_SRC_MOSC = 5'h09;
  localparam logic [4:0] COPS_SRC_ADC = 5'h0b;
  localparam logic [4:0] COPS_SRC_TPORT = 5'h0c;
  localparam logic [4:0] COPS_SRC_PER = 5'h0d;
  localparam logic [4:0] COPS_SRC_PERN = 5'h0e;
  localparam logic [4:0] COPS_SRC_HSPER = 5'h0f;
  // port A pin 4/5 field codes
  localparam logic [1:0] COPS_AF_FAULT = 2'h2;
  localparam logic [1:0] COPS_AF_TIMER = 2'h3;
endpackage

// [rtl/cops_pin_mux.sv]
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module cops_pin_mux
  import cops_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // clock sources, sampled as plain inputs
  input wire logic sys_clk_src_i,
  input wire logic clk2x_src_i,
  input wire logic clk3x_src_i,
  input wire logic relax_osc_src_i,
  input wire logic master_oscillator_clock_i,
  input wire logic adc_clk_src_i,
  input wire logic test_port_clk_i,
  input wire logic periph_clk_src_i,
  input wire logic pll_active_i,
  // port A pads 5..0
  input wire logic [5:0] pwm_i,
  input wire logic [5:0] porta_in_i,
  input wire logic [5:0] porta_peripheral_enable_i,
  input wire logic [5:0] porta_gpio_out_i,
  input wire logic [5:0] porta_gpio_oe_n_i,
  output logic [5:0] porta_out_o,
  output logic [5:0] porta_oe_n_o,
  // port B pads 7..0
  input wire logic [7:0] portb_in_i,
  input wire logic [7:0] portb_peripheral_enable_i,
  input wire logic [7:0] portb_gpio_out_i,
  input wire logic [7:0] portb_gpio_oe_n_i,
  output logic [7:0] portb_out_o,
  output logic [7:0] portb_oe_n_o,
  // peripheral side: outputs toward pads
  input wire logic uart_txd_i,
  input wire logic [1:0] i2c_out_i,
  input wire logic [1:0] i2c_oe_n_i,
  input wire logic [3:0] tmr_out_i,
  input wire logic [3:0] tmr_oe_n_i,
  input wire logic [3:0] spi_out_i,
  input wire logic [3:0] spi_oe_n_i,
  // peripheral side: inputs from pads
  output logic uart_rxd_o,
  output logic [1:0] i2c_in_o,
  output logic [3:0] tmr_in_o,
  output logic [3:0] spi_in_o,
  output logic [3:1] fault_o,
  // clocking controls
  output logic test_clock_pin_o,
  output logic timer_rate_triple_o,
  output logic pwm_rate_triple_o
);

  logic [15:0] clksel_q;
  logic [15:0] route_q;
  logic [15:0] rdata_d;
  logic test_clk_d;
  logic [5:0] a_out_d;
  logic [5:0] a_oe_n_d;
  logic [7:0] b_out_d;
  logic [7:0] b_oe_n_d;
  logic [3:0] choice_clk;
  logic [7:0] pb;
  logic [1:0] a5f;
  logic [1:0] a4f;
  logic [7:0] bp;
  logic [5:0] ap;

  // register writes; reserved bits never stored
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clksel_q <= COPS_CLKSEL_RST;
    end else if (wr_i && addr_i == COPS_CLKSEL_IDX) begin
      clksel_q <= wdata_i & COPS_CLKSEL_MASK;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      route_q <= COPS_ROUTE_RST;
    end else if (wr_i && addr_i == COPS_ROUTE_IDX) begin
      route_q <= wdata_i & COPS_ROUTE_MASK;
    end
  end

  // read data valid only in the cycle after the strobe
  always_comb begin
    rdata_d = 16'h0000;
    if (rd_i && addr_i == COPS_CLKSEL_IDX) begin
      rdata_d = clksel_q;
    end else if (rd_i && addr_i == COPS_ROUTE_IDX) begin
      rdata_d = route_q;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= rdata_d;
    end
  end

  // test clock mux: sampled clocks, so latency and glitches are accepted
  always_comb begin
    test_clk_d = 1'b0;
    if (!clksel_q[COPS_DIS_BIT]) begin
      case (clksel_q[COPS_SRC_LSB +: 5])
        COPS_SRC_SYS: test_clk_d = sys_clk_src_i;
        COPS_SRC_MOSC: test_clk_d = master_oscillator_clock_i;
        COPS_SRC_ADC: test_clk_d = adc_clk_src_i;
        COPS_SRC_TPORT: test_clk_d = test_port_clk_i;
        COPS_SRC_PER: test_clk_d = periph_clk_src_i;
        COPS_SRC_PERN: test_clk_d = ~periph_clk_src_i;
        COPS_SRC_HSPER: test_clk_d = clk3x_src_i & pll_active_i;
        default: test_clk_d = 1'b0; // unlisted codes give a quiet pin
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      test_clock_pin_o <= 1'b0;
    end else begin
      test_clock_pin_o <= test_clk_d;
    end
  end

  // rate selects; triple rate only with the pll in the clock path
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_rate_triple_o <= 1'b0;
      pwm_rate_triple_o <= 1'b0;
    end else begin
      timer_rate_triple_o <= route_q[COPS_TRATE_BIT] & pll_active_i;
      pwm_rate_triple_o <= route_q[COPS_PRATE_BIT] & pll_active_i;
    end
  end

  // field aliases
  assign pb = route_q[COPS_PB_LSB +: 8];
  assign a5f = route_q[COPS_A5_LSB +: 2];
  assign a4f = route_q[COPS_A4_LSB +: 2];
  assign ap = porta_peripheral_enable_i;
  assign bp = portb_peripheral_enable_i;
  // clock copies offered to pins A3..A0
  assign choice_clk = {relax_osc_src_i, sys_clk_src_i, clk2x_src_i, clk3x_src_i & pll_active_i};

  // pins A3..A0: gpio wins unless the pad is in peripheral mode
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_porta_low
      always_comb begin
        if (!ap[gi]) begin
          a_out_d[gi] = porta_gpio_out_i[gi];
          a_oe_n_d[gi] = porta_gpio_oe_n_i[gi];
        end else if (clksel_q[COPS_CHOICE_LSB + gi]) begin
          a_out_d[gi] = choice_clk[gi];
          a_oe_n_d[gi] = 1'b0;
        end else begin
          a_out_d[gi] = ~pwm_i[gi];
          a_oe_n_d[gi] = 1'b0;
        end
      end
    end
  endgenerate

  // pins A5 and A4: pwm, fault input or timer channel
  always_comb begin
    a_out_d[5] = porta_gpio_out_i[5];
    a_oe_n_d[5] = porta_gpio_oe_n_i[5];
    a_out_d[4] = porta_gpio_out_i[4];
    a_oe_n_d[4] = porta_gpio_oe_n_i[4];
    if (ap[5]) begin
      a_out_d[5] = pwm_i[5];
      a_oe_n_d[5] = 1'b0;
      if (a5f == COPS_AF_FAULT) begin
        a_out_d[5] = 1'b0;
        a_oe_n_d[5] = 1'b1; // fault is input only
      end else if (a5f == COPS_AF_TIMER) begin
        a_out_d[5] = tmr_out_i[3];
        a_oe_n_d[5] = tmr_oe_n_i[3];
      end
    end
    if (ap[4]) begin
      a_out_d[4] = pwm_i[4];
      a_oe_n_d[4] = 1'b0;
      if (a4f == COPS_AF_FAULT) begin
        a_out_d[4] = 1'b0;
        a_oe_n_d[4] = 1'b1;
      end else if (a4f == COPS_AF_TIMER) begin
        a_out_d[4] = tmr_out_i[2];
        a_oe_n_d[4] = tmr_oe_n_i[2];
      end
    end
  end

  // port B candidates: index by pin, first entry for route bit 0
  logic [7:0] b_alt0_out;
  logic [7:0] b_alt0_oe_n;
  logic [7:0] b_alt1_out;
  logic [7:0] b_alt1_oe_n;
  // input-only functions leave the pad undriven
  assign b_alt0_out = {uart_txd_i, 1'b0, tmr_out_i[1], tmr_out_i[0],
                       spi_out_i[0], spi_out_i[1], spi_out_i[2], spi_out_i[3]};
  assign b_alt0_oe_n = {1'b0, 1'b1, tmr_oe_n_i[1], tmr_oe_n_i[0],
                        spi_oe_n_i[0], spi_oe_n_i[1], spi_oe_n_i[2], spi_oe_n_i[3]};
  assign b_alt1_out = {i2c_out_i[0], i2c_out_i[1], 1'b0, test_clock_pin_o,
                       tmr_out_i[3], tmr_out_i[2], i2c_out_i[1], i2c_out_i[0]};
  assign b_alt1_oe_n = {i2c_oe_n_i[0], i2c_oe_n_i[1], 1'b1, 1'b0,
                        tmr_oe_n_i[3], tmr_oe_n_i[2], i2c_oe_n_i[1], i2c_oe_n_i[0]};

  generate
    for (gi = 0; gi < 8; gi++) begin : g_portb
      always_comb begin
        if (!bp[gi]) begin
          b_out_d[gi] = portb_gpio_out_i[gi];
          b_oe_n_d[gi] = portb_gpio_oe_n_i[gi];
        end else if (pb[gi]) begin
          b_out_d[gi] = b_alt1_out[gi];
          b_oe_n_d[gi] = b_alt1_oe_n[gi];
        end else begin
          b_out_d[gi] = b_alt0_out[gi];
          b_oe_n_d[gi] = b_alt0_oe_n[gi];
        end
      end
    end
  endgenerate

  // pad outputs registered; a shared output lands on every selected pad
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      porta_out_o <= 6'h00;
      porta_oe_n_o <= 6'h3f;
      portb_out_o <= 8'h00;
      portb_oe_n_o <= 8'hff;
    end else begin
      porta_out_o <= a_out_d;
      porta_oe_n_o <= a_oe_n_d;
      portb_out_o <= b_out_d;
      portb_oe_n_o <= b_oe_n_d;
    end
  end

  // pad qualifiers for inputs toward peripherals
  logic [7:0] b_sel1;
  logic [7:0] b_sel0;
  assign b_sel1 = bp & pb & portb_in_i;
  assign b_sel0 = bp & ~pb & portb_in_i;

  // inputs from two pads are ORed before the peripheral
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      uart_rxd_o <= 1'b0;
      i2c_in_o <= 2'h0;
      tmr_in_o <= 4'h0;
      spi_in_o <= 4'h0;
      fault_o <= 3'h0;
    end else begin
      uart_rxd_o <= b_sel0[6];
      i2c_in_o[0] <= b_sel1[7] | b_sel1[0];
      i2c_in_o[1] <= b_sel1[6] | b_sel1[1];
      tmr_in_o[0] <= b_sel0[4];
      tmr_in_o[1] <= b_sel0[5];
      tmr_in_o[2] <= b_sel1[2] | (ap[4] && a4f == COPS_AF_TIMER && porta_in_i[4]);
      tmr_in_o[3] <= b_sel1[3] | (ap[5] && a5f == COPS_AF_TIMER && porta_in_i[5]);
      spi_in_o <= {b_sel0[0], b_sel0[1], b_sel0[2], b_sel0[3]};
      fault_o[3] <= b_sel1[5];
      fault_o[2] <= ap[5] && a5f == COPS_AF_FAULT && porta_in_i[5];
      fault_o[1] <= ap[4] && a4f == COPS_AF_FAULT && porta_in_i[4];
    end
  end

  // checks on the registered outputs
  a_clkpin_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
    clksel_q[COPS_DIS_BIT] |=> !test_clock_pin_o)
    else $error("test clock pin not low while disabled");

  a_clkpin_sys_src: assert property (@(posedge clk_i) disable iff (rst_i)
    (!clksel_q[COPS_DIS_BIT] && clksel_q[4:0] == COPS_SRC_SYS)
    |=> test_clock_pin_o == $past(sys_clk_src_i))
    else $error("system clock source not routed");

  a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rd_i) |-> ($past(addr_i) != COPS_CLKSEL_IDX || rdata_o[15:10] == 6'h00)
    && ($past(addr_i) != COPS_ROUTE_IDX || rdata_o[13:12] == 2'h0))
    else $error("reserved bits read nonzero");

  a_write_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_i && addr_i == COPS_ROUTE_IDX) ##1 (rd_i && addr_i == COPS_ROUTE_IDX && !wr_i)
    |=> rdata_o == ($past(wdata_i, 2) & COPS_ROUTE_MASK))
    else $error("route register readback mismatch");

  a_pin_a0_pwm: assert property (@(posedge clk_i) disable iff (rst_i)
    (ap[0] && !clksel_q[COPS_CHOICE_LSB]) |=> porta_out_o[0] == !$past(pwm_i[0])
    && !porta_oe_n_o[0])
    else $error("pin A0 not inverted pwm");

  a_pin_a3_gpio: assert property (@(posedge clk_i) disable iff (rst_i)
    (!rst_i && !ap[3]) |=> porta_out_o[3] == $past(porta_gpio_out_i[3]))
    else $error("pin A3 not under gpio control");

  a_timer_rate_pll: assert property (@(posedge clk_i) disable iff (rst_i)
    !pll_active_i |=> !timer_rate_triple_o && !pwm_rate_triple_o)
    else $error("triple rate without pll");

  a_timer_rate_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    (pll_active_i && route_q[COPS_TRATE_BIT]) |=> timer_rate_triple_o)
    else $error("timer triple rate not applied");

  a_scl_or_inputs: assert property (@(posedge clk_i) disable iff (rst_i)
    (bp[7] && pb[7] && portb_in_i[7]) |=> i2c_in_o[0])
    else $error("shared scl input not ORed");

  a_pin_b4_clock: assert property (@(posedge clk_i) disable iff (rst_i)
    (bp[4] && pb[4]) |=> portb_out_o[4] == $past(test_clock_pin_o))
    else $error("pin B4 not carrying test clock");

  a_pin_a5_fault: assert property (@(posedge clk_i) disable iff (rst_i)
    (ap[5] && a5f == COPS_AF_FAULT) |=> porta_oe_n_o[5]
    && fault_o[2] == $past(porta_in_i[5]))
    else $error("pin A5 fault routing wrong");

  // sampled reset in the antecedent: pad flops are still cleared on the release edge
  a_pin_a1_double: assert property (@(posedge clk_i) disable iff (rst_i)
    (!rst_i && ap[1] && clksel_q[COPS_CHOICE_LSB + 1])
    |=> porta_out_o[1] == $past(clk2x_src_i))
    else $error("pin A1 not carrying double-rate clock");

  a_pin_a2_sysclk: assert property (@(posedge clk_i) disable iff (rst_i)
    (!rst_i && ap[2] && clksel_q[COPS_CHOICE_LSB + 2])
    |=> porta_out_o[2] == $past(sys_clk_src_i))
    else $error("pin A2 not carrying system clock");

  a_pin_a3_relax: assert property (@(posedge clk_i) disable iff (rst_i)
    (!rst_i && ap[3] && clksel_q[COPS_CHOICE_LSB + 3])
    |=> porta_out_o[3] == $past(relax_osc_src_i))
    else $error("pin A3 not carrying relaxation clock");

  a_pwm_rate_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    (pll_active_i && route_q[COPS_PRATE_BIT])
    |=> pwm_rate_triple_o)
    else $error("pwm triple rate not applied");

  a_gpio_pin_b6: assert property (@(posedge clk_i) disable iff (rst_i)
    (!rst_i && !bp[6]) |=> portb_out_o[6] == $past(portb_gpio_out_i[6])
    && portb_oe_n_o[6] == $past(portb_gpio_oe_n_i[6]))
    else $error("pin B6 not under gpio control");

  a_rxd_pad_undriven: assert property (@(posedge clk_i) disable iff (rst_i)
    (!rst_i && bp[6] && !pb[6])
    |=> portb_oe_n_o[6])
    else $error("pin B6 driven while routed to receive");

  a_clkpin_per_inv: assert property (@(posedge clk_i) disable iff (rst_i)
    (!clksel_q[COPS_DIS_BIT] && clksel_q[4:0] == COPS_SRC_PERN)
    |=> test_clock_pin_o == !$past(periph_clk_src_i))
    else $error("inverted peripheral clock not routed");

  a_sda_or_inputs: assert property (@(posedge clk_i) disable iff (rst_i)
    (bp[1] && pb[1] && portb_in_i[1])
    |=> i2c_in_o[1])
    else $error("shared sda input not ORed");

  a_pin_a4_timer: assert property (@(posedge clk_i) disable iff (rst_i)
    (!rst_i && ap[4] && a4f == COPS_AF_TIMER) |=> porta_out_o[4] == $past(tmr_out_i[2])
    && porta_oe_n_o[4] == $past(tmr_oe_n_i[2]))
    else $error("pin A4 timer routing wrong");

  a_pin_b3_mosi: assert property (@(posedge clk_i) disable iff (rst_i)
    (!rst_i && bp[3] && !pb[3])
    |=> portb_out_o[3] == $past(spi_out_i[0]))
    else $error("pin B3 not carrying spi data out");

endmodule

// [verification/cops_src_model.sv]
`timescale 1ns/1ps
// clock sources and pll status, held as levels so each mux code can
// be judged per cycle; real toggling is traded away for that
module cops_src_model (
  input wire logic clk_i,
  output logic sys_o,
  output logic x2_o,
  output logic x3_o,
  output logic relax_o,
  output logic mosc_o,
  output logic adc_o,
  output logic tport_o,
  output logic per_o,
  output logic pll_o
);
  initial begin
    {sys_o, x2_o, x3_o, relax_o, mosc_o, adc_o, tport_o, per_o, pll_o} = 9'h000;
  end
  // new levels land just after an edge
  task automatic put(input logic [7:0] v, input logic pll);
    @(posedge clk_i);
    {sys_o, x2_o, relax_o, mosc_o, adc_o, tport_o, per_o} <= {v[7:6], v[4:0]};
    x3_o <= v[5] & pll; // no high-speed clock without the pll
    pll_o <= pll;
  endtask
endmodule

// [verification/test_clock_out_and_pin_function_select.sv]
`timescale 1ns/1ps
module test_clock_out_and_pin_function_select
  import cops_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0, rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic sys_clk_src_i, clk2x_src_i, clk3x_src_i, relax_osc_src_i, master_oscillator_clock_i;
  logic adc_clk_src_i, test_port_clk_i, periph_clk_src_i, pll_active_i;
  logic [5:0] pwm_i = 6'h00, porta_in_i = 6'h00, porta_peripheral_enable_i = 6'h00;
  logic [5:0] porta_gpio_out_i = 6'h2c, porta_gpio_oe_n_i = 6'h15, porta_out_o, porta_oe_n_o;
  logic [7:0] portb_in_i = 8'h00, portb_peripheral_enable_i = 8'h00;
  logic [7:0] portb_gpio_out_i = 8'hc3, portb_gpio_oe_n_i = 8'h5a, portb_out_o, portb_oe_n_o;
  logic uart_txd_i = 1'b0;
  logic [1:0] i2c_out_i = 2'h0, i2c_oe_n_i = 2'h0, i2c_in_o;
  logic [3:0] tmr_out_i = 4'h0, tmr_oe_n_i = 4'h0, spi_out_i = 4'h0, spi_oe_n_i = 4'h0;
  logic [3:0] tmr_in_o, spi_in_o;
  logic uart_rxd_o, test_clock_pin_o, timer_rate_triple_o, pwm_rate_triple_o;
  logic [3:1] fault_o;
  int bad_count = 0;
  int samples_checked = 0;
  logic [7:0] v;
  logic [4:0] codes [7] = '{5'h00, 5'h09, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f};
  int idx [7] = '{7, 3, 2, 1, 0, 0, 5};
  logic [6:0] inv = 7'b0100000;
  logic [7:0] pins [4] = '{8'h21, 8'h80, 8'h42, 8'h0c};
  logic [6:0] pexp [4] = '{7'h03, 7'h02, 7'h04, 7'h60};
  logic [5:0] aexp [4] = '{6'h10, 6'h10, 6'h0c, 6'h23};

  always #4 clk_i = ~clk_i;

  cops_pin_mux dut (
    .clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .sys_clk_src_i, .clk2x_src_i, .clk3x_src_i, .relax_osc_src_i,
    .master_oscillator_clock_i, .adc_clk_src_i, .test_port_clk_i, .periph_clk_src_i,
    .pll_active_i, .pwm_i, .porta_in_i, .porta_peripheral_enable_i, .porta_gpio_out_i,
    .porta_gpio_oe_n_i, .porta_out_o, .porta_oe_n_o, .portb_in_i,
    .portb_peripheral_enable_i, .portb_gpio_out_i, .portb_gpio_oe_n_i, .portb_out_o,
    .portb_oe_n_o, .uart_txd_i, .i2c_out_i, .i2c_oe_n_i, .tmr_out_i, .tmr_oe_n_i,
    .spi_out_i, .spi_oe_n_i, .uart_rxd_o, .i2c_in_o, .tmr_in_o, .spi_in_o, .fault_o,
    .test_clock_pin_o, .timer_rate_triple_o, .pwm_rate_triple_o
  );

  cops_src_model src (
    .clk_i(clk_i), .sys_o(sys_clk_src_i), .x2_o(clk2x_src_i), .x3_o(clk3x_src_i),
    .relax_o(relax_osc_src_i), .mosc_o(master_oscillator_clock_i), .adc_o(adc_clk_src_i),
    .tport_o(test_port_clk_i), .per_o(periph_clk_src_i), .pll_o(pll_active_i)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(rdata_o, exp);
  endtask

  // write then read with no gap, as the port allows
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(rdata_o, exp);
  endtask

  // register write plus pad register need up to two edges
  task automatic settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    porta_peripheral_enable_i <= 6'h3f;
    pwm_i <= 6'h05;
    rd(COPS_CLKSEL_IDX, 16'h0020);
    rd(COPS_ROUTE_IDX, 16'h0000);
    settle();
    chk(16'(test_clock_pin_o), 16'h0000);
    chk(16'(porta_out_o), 16'h000a);
    $display("test reset done");
    // both rates raised together while neither module runs
    wr(COPS_CLKSEL_IDX, 16'hffff);
    wr(COPS_ROUTE_IDX, 16'hffff);
    rd(COPS_CLKSEL_IDX, 16'h03ff);
    rd(COPS_ROUTE_IDX, 16'hcfff);
    rd(8'h0c, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      v = i ? 8'haa : 8'h55;
      src.put(v, 1'b1);
      settle();
      chk(16'(porta_out_o[3:0]), 16'({v[4], v[7], v[6], v[5]}));
      chk(16'({timer_rate_triple_o, pwm_rate_triple_o}), 16'h0003);
      chk(16'(test_clock_pin_o), 16'h0000);
    end
    src.put(8'hff, 1'b0);
    settle();
    chk(16'({timer_rate_triple_o, pwm_rate_triple_o, porta_out_o[0]}), 16'h0000);
    @(posedge clk_i);
    porta_peripheral_enable_i <= 6'h00;
    portb_peripheral_enable_i <= 8'h00;
    settle();
    chk(16'({porta_out_o, porta_oe_n_o}), 16'({6'h2c, 6'h15}));
    chk({portb_out_o, portb_oe_n_o}, {8'hc3, 8'h5a});
    $display("test port a clocks done");
    for (int i = 0; i < 14; i++) begin
      v = i[0] ? 8'haa : 8'h55;
      wr(COPS_CLKSEL_IDX, {11'h000, codes[i / 2]});
      src.put(v, 1'b1);
      settle();
      chk(16'(test_clock_pin_o), 16'(v[idx[i / 2]] ^ inv[i / 2]));
    end
    wr(COPS_CLKSEL_IDX, 16'h002f);
    settle();
    chk(16'(test_clock_pin_o), 16'h0000);
    $display("test clock codes done");
    wr(COPS_ROUTE_IDX, 16'h0000);
    @(posedge clk_i);
    portb_peripheral_enable_i <= 8'hff;
    uart_txd_i <= 1'b1;
    tmr_out_i <= 4'h2;
    spi_out_i <= 4'ha;
    portb_in_i <= 8'h7f; // b6 only ever an input here
    settle();
    chk({portb_out_o, portb_oe_n_o}, 16'ha540);
    chk(16'(uart_rxd_o), 16'h0001);
    chk(16'({tmr_in_o, spi_in_o}), 16'h003f);
    wr_rd(COPS_ROUTE_IDX, 16'h3ff0, 16'h0ff0);
    @(posedge clk_i);
    i2c_out_i <= 2'h1;
    tmr_out_i <= 4'h8;
    settle();
    chk({portb_out_o, portb_oe_n_o}, 16'h8920);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      portb_in_i <= pins[i];
      settle();
      chk(16'({tmr_in_o, i2c_in_o, fault_o[3]}), 16'(pexp[i]));
    end
    $display("test port b done");
    @(posedge clk_i);
    porta_peripheral_enable_i <= 6'h3f;
    porta_in_i <= 6'h30;
    portb_in_i <= 8'h00;
    pwm_i <= 6'h10;
    for (int i = 0; i < 4; i++) begin
      wr(COPS_ROUTE_IDX, 16'h0ff0 | 16'(i * 5));
      settle();
      chk(16'({porta_out_o[5:4], fault_o[2:1], tmr_in_o[3:2]}), 16'(aexp[i]));
    end
    $display("test port a fields done");
    report_and_stop();
  end
endmodule
